// File: inc/pcw_pkg.sv
package pcw_pkg;
	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_PORT_A = 8'h05;
	localparam logic [7:0] IDX_PORT_C = 8'h07;
	localparam logic [7:0] IDX_IRQ_CTL = 8'h0b;
	localparam logic [7:0] IDX_CMP_CFG = 8'h19;
	localparam logic [7:0] IDX_OPTION = 8'h81;
	localparam logic [7:0] IDX_DIR_A = 8'h85;
	localparam logic [7:0] IDX_DIR_C = 8'h87;
	localparam logic [7:0] IDX_PWR_CTL = 8'h8e;
	localparam logic [7:0] IDX_PULL_EN = 8'h95;
	localparam logic [7:0] IDX_IOC_EN = 8'h96;
	localparam logic [7:0] IDX_PULL_DIR = 8'h97;
	localparam logic [7:0] IDX_DEV_CFG = 8'ha0;
	localparam int unsigned ADDR_W = 10;
	// reset values
	localparam logic [7:0] RST_IRQ_CTL = 8'h00;
	localparam logic [7:0] RST_CMP_CFG = 8'h00;
	localparam logic [7:0] RST_OPTION = 8'hff;
	localparam logic [5:0] RST_DIR = 6'h3f;
	localparam logic [5:0] RST_PULL = 6'h37;
	localparam logic [5:0] RST_IOC = 6'h00;
	localparam logic [5:0] RST_LAT = 6'h00;
	localparam logic [3:0] RST_DEV_CFG = 4'h0;
	localparam logic RST_ULP = 1'b0;
	// field positions
	localparam int unsigned IRQ_GLOBAL_EN = 7;
	localparam int unsigned IRQ_CHANGE_EN = 3;
	localparam int unsigned IRQ_CHANGE_FLAG = 0;
	localparam int unsigned PWR_ULP_EN = 5;
	localparam int unsigned CFG_CRYSTAL = 0;
	localparam int unsigned CFG_CLEAR_PIN = 1;
	localparam int unsigned CFG_WAKE_RST = 2;
	localparam int unsigned CFG_SLEEP = 3;
	localparam logic [5:0] PULL_MASK = 6'h37;
	localparam logic [2:0] CM_ALL_DIGITAL = 3'h7;
	// pin group, port a in [5:0], port c in [11:6]
	typedef struct packed {
		logic [5:0] c;
		logic [5:0] a;
	} pcw_pins_t;
	// signals arriving from neighbouring blocks
	typedef struct packed {
		logic cmp1_out;
		logic cmp1_out_en;
		logic cmp2_out;
		logic cmp2_out_en;
		logic clk_out;
		logic clk_out_en;
		logic prog_mode;
		logic prog_data_o;
		logic prog_data_oe;
	} pcw_periph_in_t;
	// signals handed to neighbouring blocks
	typedef struct packed {
		logic timer_zero_clock_in;
		logic ext_int_in;
		logic timer_one_gate_in;
		logic timer_one_clock_in;
		logic prog_serial_clock;
		logic prog_serial_data;
		logic master_clear_n;
		logic slow_discharge_sink;
		logic [3:0] analog_sel;
	} pcw_periph_out_t;
endpackage : pcw_pkg

// File: hw/pcw_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser; only the second stage is visible
module pcw_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r; // first stage, read by q only

	// both stages share the enable so nothing slips while frozen
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : pcw_sync

// File: hw/pcw_pin_cell.sv
`timescale 1ns/1ps
// one pad: output mux, drive enable and digital read path
module pcw_pin_cell (
	input wire logic lat,
	input wire logic dir_in,
	input wire logic alt_en,
	input wire logic alt_val,
	input wire logic force_in,
	input wire logic analog,
	input wire logic pin_sync,
	output logic pad_o,
	output logic pad_oe,
	output logic rd
);
	// alternate function takes the pad over from the port latch
	always_comb begin
		pad_o = alt_en ? alt_val : lat;
	end

	// an owning function or analog use keeps the driver off
	always_comb begin
		pad_oe = !force_in && !analog && (alt_en || !dir_in);
	end

	// analog pins give zero to the digital side
	always_comb begin
		rd = analog ? 1'b0 : pin_sync;
	end
endmodule : pcw_pin_cell

// File: hw/pcw_port_ctrl.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
module pcw_port_ctrl import pcw_pkg::*; (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic por_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pcw_pins_t pad_in,
	output pcw_pins_t pad_out,
	output pcw_pins_t pad_oe,
	input wire pcw_periph_in_t periph_in,
	output pcw_periph_out_t periph_out,
	output logic change_irq,
	output logic wake_vector,
	output logic wake_next
);
	logic [1:0] rst_sync_r; // reset release chain
	logic rst_n; // released reset for the design
	logic [1:0] por_sync_r; // power-on release chain
	logic por_rst_n; // released power-on reset
	logic [5:0] lat_a_r; // port a output latch
	logic [5:0] lat_c_r; // port c output latch
	logic [5:0] dir_a_r; // port a direction, 1 = input
	logic [5:0] dir_c_r; // port c direction, 1 = input
	logic [5:0] ioc_en_r; // per-pin change enables
	logic [5:0] pull_en_r; // pull enables, storage only
	logic [5:0] pull_dir_r; // pull direction, storage only
	logic [7:0] irq_ctl_r; // interrupt control
	logic [7:0] cmp_cfg_r; // comparator configuration
	logic [7:0] option_r; // option settings
	logic ulp_en_r; // slow discharge wake enable
	logic [3:0] dev_cfg_r; // crystal, clear, wake reset, sleep
	logic [5:0] old_a_r; // port a value at last access
	logic [31:0] prdata_r; // read data captured in setup
	logic pslverr_r; // error captured in setup
	logic wake_vec_r; // wake pulse, vector taken
	logic wake_next_r; // wake pulse, fall through
	logic [11:0] pin_sync; // synchronised pad levels
	logic [11:0] cell_lat; // latch bit per pad
	logic [11:0] cell_dir; // direction bit per pad
	logic [11:0] cell_alt_en; // alternate drive per pad
	logic [11:0] cell_alt_val; // alternate level per pad
	logic [11:0] cell_force; // pad owned as input
	logic [11:0] cell_analog; // pad in analog use
	logic [11:0] cell_rd; // digital read value per pad
	logic [11:0] cell_pad_o; // pad output level
	logic [11:0] cell_pad_oe; // pad drive enable
	logic [7:0] idx; // register index from the address
	logic aligned; // low address bits clear
	logic hit; // index names a register
	logic setup_ph; // apb setup cycle
	logic access_ph; // apb access cycle, taken now
	logic wr_acc; // write takes effect this edge
	logic rd_acc; // read completes this edge
	logic [7:0] rd_val; // read mux output
	logic crystal; // oscillator owns pins a4, a5
	logic clear_pin_on; // pin a3 is master clear
	logic sleeping; // device asleep
	logic analog_on; // comparator owns analog pins
	logic [5:0] ioc_eff; // enables after masking
	logic [5:0] ioc_view; // enables as software sees them
	logic [5:0] rd_a; // port a read value
	logic mismatch; // any enabled pin differs
	logic port_a_touch; // port a read or write done
	logic wake_evt; // change seen while asleep

	// reset release; power-on also pulls the design reset
	always_ff @(posedge core_clk or negedge nrst or negedge por_n) begin
		if (!nrst || !por_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// separate power-on release: only this clears the last-read latch
	always_ff @(posedge core_clk or negedge por_n) begin
		if (!por_n) begin
			por_sync_r <= 2'b00;
		end else begin
			por_sync_r <= {por_sync_r[0], 1'b1};
		end
	end
	assign por_rst_n = por_sync_r[1];

	// pads go through two flops before anyone compares them
	pcw_sync #(
		.WIDTH(12)
	) u_pin_sync (
		.clk(core_clk),
		.rst_n(rst_n),
		.ce(clk_en),
		.d(pad_in),
		.q(pin_sync)
	);

	// configuration views
	assign crystal = dev_cfg_r[CFG_CRYSTAL];
	assign clear_pin_on = dev_cfg_r[CFG_CLEAR_PIN];
	assign sleeping = dev_cfg_r[CFG_SLEEP];
	assign analog_on = cmp_cfg_r[2:0] != CM_ALL_DIGITAL;

	// apb decode; the slave answers in the access cycle
	assign idx = paddr[ADDR_W-1:2];
	assign aligned = paddr[1:0] == 2'b00;
	assign setup_ph = psel && !penable && clk_en;
	assign access_ph = psel && penable && clk_en;
	assign wr_acc = access_ph && pwrite && hit && aligned;
	assign rd_acc = access_ph && !pwrite && hit && aligned;
	// a frozen block must not complete a transfer
	assign pready = psel && penable && clk_en;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r && pready;

	// index lookup for the map
	always_comb begin
		unique case (idx)
			IDX_PORT_A, IDX_PORT_C, IDX_IRQ_CTL, IDX_CMP_CFG,
			IDX_OPTION, IDX_DIR_A, IDX_DIR_C, IDX_PWR_CTL,
			IDX_PULL_EN, IDX_IOC_EN, IDX_PULL_DIR,
			IDX_DEV_CFG: hit = 1'b1;
			default: hit = 1'b0; // unmapped
		endcase
	end

	// enable masking: crystal takes pins 4,5, sleep with wake reset pin 3
	always_comb begin
		ioc_view = ioc_en_r;
		if (crystal) begin
			ioc_view[5:4] = 2'b00;
		end
		ioc_eff = ioc_view;
		if (dev_cfg_r[CFG_WAKE_RST] && sleeping) begin
			ioc_eff[3] = 1'b0;
		end
	end

	// port a reads: analog pins give zero, a3 hidden under master clear
	always_comb begin
		rd_a = cell_rd[5:0];
		if (clear_pin_on) begin
			rd_a[3] = 1'b0;
		end
	end

	// mismatch against the value seen at the last port access
	// uses the raw synced level so analog masking cannot hide a
	// falling discharge pin
	assign mismatch = |((pin_sync[5:0] ^ old_a_r) & ioc_eff);
	assign port_a_touch = (wr_acc || rd_acc) && idx == IDX_PORT_A;
	assign wake_evt = sleeping && irq_ctl_r[IRQ_CHANGE_FLAG]
		&& irq_ctl_r[IRQ_CHANGE_EN];

	// read mux; unimplemented bits read zero
	always_comb begin
		rd_val = 8'h00;
		unique case (idx)
			IDX_PORT_A: rd_val = {2'b00, rd_a};
			IDX_PORT_C: rd_val = {2'b00, cell_rd[11:6]};
			IDX_IRQ_CTL: rd_val = irq_ctl_r;
			IDX_CMP_CFG: rd_val = cmp_cfg_r;
			IDX_OPTION: rd_val = option_r;
			IDX_DIR_A: begin
				rd_val = {2'b00, dir_a_r | 6'h08};
				if (crystal) begin
					rd_val[5:4] = 2'b11;
				end
			end
			IDX_DIR_C: rd_val = {2'b00, dir_c_r};
			IDX_PWR_CTL: rd_val = {2'b00, ulp_en_r, 5'h00};
			IDX_PULL_EN: rd_val = {2'b00, pull_en_r};
			IDX_IOC_EN: rd_val = {2'b00, ioc_view};
			IDX_PULL_DIR: rd_val = {2'b00, pull_dir_r};
			IDX_DEV_CFG: rd_val = {4'h0, dev_cfg_r};
			default: rd_val = 8'h00;
		endcase
	end

	// read data and error are sampled in setup so they leave flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup_ph) begin
			// a refused access hands back zero, not the register
			prdata_r <= (hit && aligned) ? {24'h00_0000, rd_val}
				: 32'h0000_0000;
			pslverr_r <= !hit || !aligned;
		end
	end

	// port latches and directions
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lat_a_r <= RST_LAT;
			lat_c_r <= RST_LAT;
			dir_a_r <= RST_DIR;
			dir_c_r <= RST_DIR;
		end else if (wr_acc) begin
			unique case (idx)
				IDX_PORT_A: lat_a_r <= pwdata[5:0];
				IDX_PORT_C: lat_c_r <= pwdata[5:0];
				IDX_DIR_A: dir_a_r <= pwdata[5:0];
				IDX_DIR_C: dir_c_r <= pwdata[5:0];
				default: ;
			endcase
		end
	end

	// plain configuration registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ioc_en_r <= RST_IOC;
			pull_en_r <= RST_PULL;
			pull_dir_r <= RST_PULL;
			cmp_cfg_r <= RST_CMP_CFG;
			option_r <= RST_OPTION;
			ulp_en_r <= RST_ULP;
		end else if (wr_acc) begin
			unique case (idx)
				IDX_IOC_EN: ioc_en_r <= pwdata[5:0];
				IDX_PULL_EN: pull_en_r <= pwdata[5:0] & PULL_MASK;
				IDX_PULL_DIR: pull_dir_r <= pwdata[5:0] & PULL_MASK;
				IDX_CMP_CFG: cmp_cfg_r <= pwdata[7:0];
				IDX_OPTION: option_r <= pwdata[7:0];
				IDX_PWR_CTL: ulp_en_r <= pwdata[PWR_ULP_EN];
				default: ;
			endcase
		end
	end

	// interrupt control; a live mismatch beats a software clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_ctl_r <= RST_IRQ_CTL;
		end else if (clk_en) begin
			if (wr_acc && idx == IDX_IRQ_CTL) begin
				irq_ctl_r <= pwdata[7:0];
			end
			if (mismatch) begin
				irq_ctl_r[IRQ_CHANGE_FLAG] <= 1'b1;
			end
		end
	end

	// device config; a wake ends sleep, winning over a software write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_cfg_r <= RST_DEV_CFG;
		end else if (clk_en) begin
			if (wr_acc && idx == IDX_DEV_CFG) begin
				dev_cfg_r <= pwdata[3:0];
			end
			if (wake_evt) begin
				dev_cfg_r[CFG_SLEEP] <= 1'b0;
			end
		end
	end

	// last-access snapshot; survives every reset but power-on
	always_ff @(posedge core_clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			old_a_r <= RST_LAT;
		end else if (port_a_touch) begin
			old_a_r <= pin_sync[5:0];
		end
	end

	// wake pulses: vector if the global enable is set, else next
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_vec_r <= 1'b0;
			wake_next_r <= 1'b0;
		end else if (clk_en) begin
			wake_vec_r <= wake_evt && irq_ctl_r[IRQ_GLOBAL_EN];
			wake_next_r <= wake_evt && !irq_ctl_r[IRQ_GLOBAL_EN];
		end
	end
	assign wake_vector = wake_vec_r;
	assign wake_next = wake_next_r;

	// recognised only under the global enable
	assign change_irq = irq_ctl_r[IRQ_GLOBAL_EN]
		&& irq_ctl_r[IRQ_CHANGE_EN]
		&& irq_ctl_r[IRQ_CHANGE_FLAG];

	// per-pad control vectors
	assign cell_lat = {lat_c_r, lat_a_r};
	assign cell_dir = {dir_c_r, dir_a_r | 6'h08};

	// alternate drivers: prog data a0, comparators a2/c4, clock a4
	always_comb begin
		cell_alt_en = 12'h000;
		cell_alt_val = 12'h000;
		// programmer data overrides the port on a0
		cell_alt_en[0] = periph_in.prog_mode && periph_in.prog_data_oe;
		cell_alt_val[0] = periph_in.prog_data_o;
		cell_alt_en[2] = periph_in.cmp1_out_en;
		cell_alt_val[2] = periph_in.cmp1_out;
		// clock out only when the oscillator leaves the pin free
		cell_alt_en[4] = periph_in.clk_out_en && !crystal;
		cell_alt_val[4] = periph_in.clk_out;
		// second comparator output shares c4
		cell_alt_en[10] = periph_in.cmp2_out_en;
		cell_alt_val[10] = periph_in.cmp2_out;
	end

	// pads taken over as inputs by other owners
	always_comb begin
		cell_force = 12'h000;
		cell_force[1] = periph_in.prog_mode;
		cell_force[3] = 1'b1;
		cell_force[4] = crystal;
		cell_force[5] = crystal;
		// the sink already pulls a0; the output driver must not fight it
		cell_force[0] = ulp_en_r && !cell_alt_en[0];
	end

	// comparator analog inputs: a0, a1, c0, c1
	always_comb begin
		cell_analog = 12'h000;
		cell_analog[0] = analog_on;
		cell_analog[1] = analog_on;
		cell_analog[6] = analog_on;
		cell_analog[7] = analog_on;
	end

	// one cell per pad on both ports
	genvar gi;
	generate
		for (gi = 0; gi < 12; gi++) begin : g_pad
			pcw_pin_cell u_cell (
				.lat(cell_lat[gi]),
				.dir_in(cell_dir[gi]),
				.alt_en(cell_alt_en[gi]),
				.alt_val(cell_alt_val[gi]),
				.force_in(cell_force[gi]),
				.analog(cell_analog[gi]),
				.pin_sync(pin_sync[gi]),
				.pad_o(cell_pad_o[gi]),
				.pad_oe(cell_pad_oe[gi]),
				.rd(cell_rd[gi])
			);
		end
	endgenerate
	assign pad_out = cell_pad_o;
	assign pad_oe = cell_pad_oe;

	// signals handed to neighbours: pin inputs from synchronised levels, sink and analog select from registers
	always_comb begin
		periph_out.prog_serial_data = pin_sync[0];
		periph_out.prog_serial_clock = pin_sync[1];
		periph_out.timer_zero_clock_in = pin_sync[2];
		periph_out.ext_int_in = pin_sync[2];
		periph_out.master_clear_n = clear_pin_on ? pin_sync[3] : 1'b1;
		periph_out.timer_one_gate_in = pin_sync[4];
		periph_out.timer_one_clock_in = pin_sync[5];
		periph_out.slow_discharge_sink = ulp_en_r;
		periph_out.analog_sel = {4{analog_on}};
	end
endmodule : pcw_port_ctrl

// File: bench/pcw_port_ctrl_sva.sv
`timescale 1ns/1ps
// port-level checker, sees only the top ports
module pcw_chk import pcw_pkg::*; (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic por_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire pcw_pins_t pad_in,
	input wire pcw_pins_t pad_oe,
	input wire pcw_periph_in_t periph_in,
	input wire pcw_periph_out_t periph_out,
	input wire logic change_irq,
	input wire logic wake_vector,
	input wire logic wake_next
);
	logic rst_n; // either reset source
	logic [2:0] up_r; // edges since release, saturating
	assign rst_n = nrst & por_n;
	// sync checks wait until reset copy and stages have filled
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			up_r <= 3'h0;
		end else if (up_r != 3'h7) begin
			up_r <= up_r + 3'h1;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	ready_comb_a: assert property (pready == (psel && penable && clk_en))
		else $error("pready not zero-wait");
	align_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused read carries data");
	upper_zero_a: assert property (prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	sync_int_a: assert property (up_r == 3'h7 && $past(clk_en)
		&& $past(clk_en, 2) |-> periph_out.ext_int_in == $past(pad_in.a[2], 2))
		else $error("interrupt input not two-stage synced");
	sync_pclk_a: assert property (up_r == 3'h7 && $past(clk_en)
		&& $past(clk_en, 2)
		|-> periph_out.prog_serial_clock == $past(pad_in.a[1], 2))
		else $error("programming clock not two-stage synced");
	wake_pulse_a: assert property (wake_vector || wake_next
		|=> !wake_vector && !wake_next) else $error("wake pulse too long");
	vector_irq_a: assert property (wake_vector |-> $past(change_irq))
		else $error("vector wake without enabled interrupt");
	next_irq_a: assert property (wake_next |-> !$past(change_irq))
		else $error("next-instruction wake with interrupt live");
	sink_off_a: assert property (periph_out.slow_discharge_sink
		&& !periph_in.prog_data_oe |-> !pad_oe.a[0])
		else $error("pin a0 driven while sink is on");
endmodule : pcw_chk
bind pcw_port_ctrl pcw_chk chk_i (.core_clk, .nrst, .por_n, .clk_en, .psel,
	.penable, .paddr, .prdata, .pready, .pslverr, .pad_in, .pad_oe, .periph_in,
	.periph_out, .change_irq, .wake_vector, .wake_next);

// File: bench/pcw_pad_model.sv
`timescale 1ns/1ps
// pads plus the rc network on pin a0
module pcw_pad_model import pcw_pkg::*; (
	input wire logic core_clk,
	input wire logic cap_on,
	input wire logic sink,
	input wire pcw_pins_t ext,
	input wire pcw_pins_t pad_out,
	input wire pcw_pins_t pad_oe,
	output pcw_pins_t pad_in
);
	logic [7:0] cap_r = 8'h00; // capacitor charge in steps
	// driving high charges at once; the sink bleeds one step a cycle
	always @(posedge core_clk) begin
		if (pad_oe.a[0]) begin
			cap_r <= pad_out.a[0] ? 8'hff : 8'h00;
		end else if (sink && cap_r != 8'h00) begin
			cap_r <= cap_r - 8'h01;
		end
	end
	// a driven pad reads back its own level, else the far side; undriven a0 reads the capacitor while cap_on
	always_comb begin
		pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
		if (cap_on && !pad_oe.a[0]) begin
			pad_in.a[0] = cap_r[7];
		end
	end
endmodule : pcw_pad_model

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench import pcw_pkg::*;;
	logic core_clk, nrst, por_n, clk_en, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic pready, pslverr, change_irq, wake_vector, wake_next, cap_on, lerr;
	pcw_pins_t ext, pad_in, pad_out, pad_oe;
	pcw_periph_in_t pin_c;
	pcw_periph_out_t pout;
	int bad_count, comparisons;
	logic [7:0] ri[9] = '{IDX_IRQ_CTL, IDX_CMP_CFG, IDX_OPTION, IDX_DIR_A,
		IDX_DIR_C, IDX_PULL_EN, IDX_IOC_EN, IDX_PULL_DIR, IDX_PWR_CTL};
	logic [7:0] rv[9] = '{8'h00, 8'h00, 8'hff, 8'h3f, 8'h3f, 8'h37, 8'h00,
		8'h37, 8'h00};
	pcw_port_ctrl pcw_port_ctrl_i (.core_clk, .nrst, .por_n, .clk_en, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pad_in,
		.pad_out, .pad_oe, .periph_in(pin_c), .periph_out(pout), .change_irq,
		.wake_vector, .wake_next);
	pcw_pad_model pcw_pad_model_i (.core_clk, .cap_on,
		.sink(pout.slow_discharge_sink), .ext, .pad_out, .pad_oe, .pad_in);
	// free-running core clock
	always #5 core_clk = ~core_clk;
	task stop_test;
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		comparisons++;
		if (seen !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, seen);
		end
	endtask : chk
	// one apb transfer; entered just after a rising edge
	task xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			stop_test;
		end
		rdv = prdata;
		lerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge keeps two transfers out of one time step
		@(posedge core_clk);
	endtask : xfer
	task rdc(input logic [7:0] idx, input logic [7:0] e, input string nm);
		xfer(1'b0, idx, 8'h00);
		chk(nm, rdv, {24'h0, e});
	endtask : rdc
	task settle;
		repeat (5) @(posedge core_clk);
	endtask : settle
	initial begin
		int n;
		core_clk = 1'b0;
		nrst = 1'b0;
		por_n = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		ext = '0;
		pin_c = '0;
		cap_on = 1'b0;
		bad_count = 0;
		comparisons = 0;
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		por_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		// reset values and an unmapped place
		for (int i = 0; i < 9; i++) rdc(ri[i], rv[i], "reset value");
		xfer(1'b0, 8'h40, 8'h00);
		chk("unmapped error", {31'h0, lerr}, 32'h1);
		wr_ioc: begin
			xfer(1'b1, IDX_IOC_EN, 8'hff);
			rdc(IDX_IOC_EN, 8'h3f, "ioc upper bits");
			xfer(1'b1, IDX_DEV_CFG, 8'h01);
			rdc(IDX_IOC_EN, 8'h0f, "ioc crystal mode");
			xfer(1'b1, IDX_DEV_CFG, 8'h00);
			rdc(IDX_IOC_EN, 8'h3f, "ioc restored");
			xfer(1'b1, IDX_IOC_EN, 8'h00);
		end
		$display("test registers done");
		// analog pins read zero until the comparator is set digital
		ext <= 12'hfff;
		settle;
		rdc(IDX_PORT_A, 8'h3c, "port a analog");
		rdc(IDX_PORT_C, 8'h3c, "port c analog");
		xfer(1'b1, IDX_CMP_CFG, {5'h0, CM_ALL_DIGITAL});
		rdc(IDX_PORT_A, 8'h3f, "port a digital");
		rdc(IDX_PORT_C, 8'h3f, "port c digital");
		xfer(1'b1, IDX_DIR_C, 8'h00);
		xfer(1'b1, IDX_PORT_C, 8'h15);
		chk("port c drive", {26'h0, pad_oe.c}, 32'h3f);
		chk("port c level", {26'h0, pad_out.c}, 32'h15);
		// the driven level needs the two sync stages before a read
		settle;
		rdc(IDX_PORT_C, 8'h15, "port c readback");
		xfer(1'b1, IDX_DIR_C, 8'h3f);
		// comparator output takes pin a2 over from the port latch
		pin_c.cmp1_out_en <= 1'b1;
		pin_c.cmp1_out <= 1'b1;
		@(posedge core_clk);
		chk("a2 comparator", {30'h0, pad_oe.a[2], pad_out.a[2]}, 32'h3);
		pin_c <= '0;
		$display("test analog done");
		// change detection against the last-read snapshot
		xfer(1'b1, IDX_IOC_EN, 8'h01);
		xfer(1'b1, IDX_IRQ_CTL, 8'h08);
		rdc(IDX_PORT_A, 8'h3f, "snapshot");
		ext.a[1] <= 1'b0;
		settle;
		rdc(IDX_IRQ_CTL, 8'h08, "disabled pin quiet");
		ext.a[0] <= 1'b0;
		settle;
		rdc(IDX_IRQ_CTL, 8'h09, "flag on change");
		chk("irq masked", {31'h0, change_irq}, 32'h0);
		xfer(1'b1, IDX_IRQ_CTL, 8'h08);
		rdc(IDX_IRQ_CTL, 8'h09, "flag sticky");
		rdc(IDX_PORT_A, 8'h3c, "port touch");
		xfer(1'b1, IDX_IRQ_CTL, 8'h08);
		rdc(IDX_IRQ_CTL, 8'h08, "flag cleared");
		xfer(1'b1, IDX_IRQ_CTL, 8'h88);
		ext.a[0] <= 1'b1;
		settle;
		chk("irq live", {31'h0, change_irq}, 32'h1);
		rdc(IDX_PORT_A, 8'h3d, "port touch");
		xfer(1'b1, IDX_IRQ_CTL, 8'h00);
		$display("test change done");
		// slow-discharge wake, to the vector and to the next instruction
		cap_on <= 1'b1;
		for (int g = 1; g >= 0; g--) begin
			xfer(1'b1, IDX_PORT_A, 8'h01);
			xfer(1'b1, IDX_DIR_A, 8'h3e);
			xfer(1'b1, IDX_IOC_EN, 8'h01);
			xfer(1'b1, IDX_DIR_A, 8'h3f);
			xfer(1'b1, IDX_PWR_CTL, 8'h20);
			chk("sink on", {31'h0, pout.slow_discharge_sink}, 32'h1);
			rdc(IDX_PORT_A, 8'h3d, "charged");
			xfer(1'b1, IDX_IRQ_CTL, {g[0], 7'h08});
			xfer(1'b1, IDX_DEV_CFG, 8'h08);
			n = 0;
			while (wake_vector !== 1'b1 && wake_next !== 1'b1 && n < 400) begin
				@(posedge core_clk);
				n++;
			end
			chk("wake seen", {31'h0, n < 400}, 32'h1);
			chk("wake vector", {31'h0, wake_vector}, {31'h0, g[0]});
			chk("wake next", {31'h0, wake_next}, {31'h0, !g[0]});
			@(posedge core_clk);
			rdc(IDX_DEV_CFG, 8'h00, "sleep ended");
			xfer(1'b1, IDX_PWR_CTL, 8'h00);
			rdc(IDX_PORT_A, 8'h3c, "discharged");
			xfer(1'b1, IDX_IRQ_CTL, 8'h00);
		end
		cap_on <= 1'b0;
		$display("test wake done");
		// pin 3 enable ignored while sleeping with wake reset on
		xfer(1'b1, IDX_IOC_EN, 8'h08);
		xfer(1'b1, IDX_IRQ_CTL, 8'h08);
		rdc(IDX_PORT_A, 8'h3d, "snapshot");
		xfer(1'b1, IDX_DEV_CFG, 8'h0c);
		ext.a[3] <= 1'b0;
		settle;
		rdc(IDX_IRQ_CTL, 8'h08, "pin3 ignored");
		xfer(1'b1, IDX_DEV_CFG, 8'h02);
		settle;
		rdc(IDX_IRQ_CTL, 8'h09, "pin3 awake");
		chk("master clear", {31'h0, pout.master_clear_n}, 32'h0);
		$display("test pin3 done");
		stop_test;
	end
endmodule : testbench
